// [rtl/cmrbe_core.sv]
// Fetch and execute of move, rotate and branch instructions.
// Assumes a memory on the shared address/data pins answering within the
// configured wait states; register space lives here in a 256-byte SRAM.
module cmrbe_core
  import cmrbe_pkg::*;
(
  input  wire logic            clk,
  input  wire logic            rst_n,
  input  wire logic            run,
  input  wire logic [WS_W-1:0] codeWaitStates,
  input  wire logic [WS_W-1:0] dataWaitStates,
  input  wire logic [7:0]      memDataIn,
  output cmrbe_mem_bus_t       memBus,
  output logic      [15:0]     progCounter,
  output cmrbe_flags_t         flags,
  input  wire logic            flagsLoad,
  input  wire cmrbe_flags_t    flagsIn,
  input  wire logic            regLoadEn,
  input  wire logic [7:0]      regLoadAddr,
  input  wire logic [7:0]      regLoadData,
  input  wire logic [7:0]      regPeekAddr,
  output logic      [7:0]      regPeekData,
  output logic                 instrDone,
  output logic                 unsupportedOp,
  output logic                 intReturn
);
  cmrbe_state_t    state_reg;
  logic [15:0]     pc_reg;
  logic [7:0]      ir0_reg;
  logic [7:0]      ir1_reg;
  logic [7:0]      ir2_reg;
  logic [1:0]      byteIdx_reg;
  logic [1:0]      bytes_reg;
  logic [WS_W-1:0] wsCnt_reg;
  logic [CYC_W-1:0] cycCnt_reg;
  logic [CYC_W-1:0] total_reg;
  logic [15:0]     memPtr_reg;
  logic [7:0]      memWData_reg;
  cmrbe_flags_t    flags_reg;
  logic [7:0]      sram [256];

  logic [7:0]      r1, r2, r1Ind, r2Ind, popVal;
  logic [15:0]     farPtr1, farPtr2, stackTop;
  logic [7:0]      rotOut;
  logic            rotCarry, isRotate, isMove, isFarWrite, isFarOp;
  logic [WS_W-1:0] memWs;
  logic            fetchLast, memLast, lastCycle, finish, taken;
  logic            isBranch, branchEnd;
  cmrbe_timing_t   fetchTiming, opTiming;
  logic [1:0]      bytesNeeded;
  logic            wEn, pEn;
  logic [7:0]      wAddr, wData, pAddr, pData;

  // Register-space operands and their indirections
  assign r1     = sram[ir1_reg];
  assign r2     = sram[ir2_reg];
  assign r1Ind  = sram[r1];
  assign r2Ind  = sram[r2];
  assign popVal = sram[8'(r2 + PTR_STEP)];
  // Low address bit is forced so an odd pointer still reads a pair
  assign farPtr1 = {sram[{ir1_reg[7:1], 1'b1}], sram[{ir1_reg[7:1], 1'b0}]};
  assign farPtr2 = {sram[{ir2_reg[7:1], 1'b1}], sram[{ir2_reg[7:1], 1'b0}]};

  assign isMove     = ir0_reg >= OP_MOV_DIRECT && ir0_reg <= OP_DATA_WRITE;
  assign isRotate   = ir0_reg >= OP_ROTATE_LEFT
                   && ir0_reg <= OP_ARITH_RIGHT_SHIFT;
  assign isFarOp    = ir0_reg >= OP_CODE_READ && ir0_reg <= OP_DATA_WRITE;
  assign isFarWrite = ir0_reg == OP_CODE_WRITE || ir0_reg == OP_DATA_WRITE;
  assign memWs      = cmrbe_is_data_move(ir0_reg) ? dataWaitStates
                                                  : codeWaitStates;
  assign fetchLast  = wsCnt_reg == codeWaitStates;
  assign memLast    = wsCnt_reg == memWs;
  assign lastCycle  = cycCnt_reg == total_reg - CYC_W'(1);
  assign fetchTiming = cmrbe_timing(memDataIn);
  assign opTiming    = cmrbe_timing(ir0_reg);
  assign bytesNeeded = byteIdx_reg == '0 ? fetchTiming.bytes
                                         : bytes_reg;
  assign isBranch    = ir0_reg >= OP_JUMP_IF_CARRY && ir0_reg <= OP_CALL;
  // Branches resolve in their last fetch cycle; an extra execute cycle
  // would overrun their three-cycle budget
  assign branchEnd   = state_reg == ST_FETCH && fetchLast
                    && byteIdx_reg == BYTE_TWO && isBranch;
  assign finish = branchEnd
               || (state_reg == ST_EXEC && !isFarOp && lastCycle)
               || (state_reg == ST_MEM && memLast && lastCycle)
               || (state_reg == ST_PAD && lastCycle);

  always_comb
  begin
    rotOut   = r1;
    rotCarry = flags_reg.carry;
    case (ir0_reg)
      OP_ROTATE_LEFT:            {rotCarry, rotOut} = {r1[7], r1[6:0], r1[7]};
      OP_ROTATE_RIGHT:           {rotOut, rotCarry} = {r1[0], r1[7:1], r1[0]};
      OP_ROTATE_LEFT_VIA_CARRY:  {rotCarry, rotOut} = {r1, flags_reg.carry};
      OP_ROTATE_RIGHT_VIA_CARRY: {rotOut, rotCarry} = {flags_reg.carry, r1};
      OP_LOGICAL_LEFT_SHIFT:     {rotCarry, rotOut} = {r1, 1'b0};
      OP_LOGICAL_RIGHT_SHIFT:    {rotOut, rotCarry} = {1'b0, r1};
      OP_ARITH_RIGHT_SHIFT:      {rotOut, rotCarry} = {r1[7], r1};
      default:                   rotOut = r1;
    endcase
  end

  always_comb
  begin
    case (ir0_reg)
      OP_JUMP_IF_CARRY:    taken = flags_reg.carry;
      OP_JUMP_IF_NO_CARRY: taken = !flags_reg.carry;
      OP_JUMP_IF_ZERO:     taken = flags_reg.zero;
      OP_JUMP_IF_NONZERO:  taken = !flags_reg.zero;
      OP_JUMP_IF_NEGATIVE: taken = flags_reg.sign;
      OP_JUMP_IF_POSITIVE: taken = !flags_reg.sign;
      OP_JUMP, OP_CALL:    taken = 1'b1;
      default:             taken = 1'b0;
    endcase
  end

  // Register-space writes: w carries the result, p a pointer update
  always_comb
  begin
    wEn   = 1'b0;
    wAddr = ir1_reg;
    wData = r2;
    pEn   = 1'b0;
    pAddr = ir2_reg;
    pData = 8'(r2 + PTR_STEP);
    if (state_reg == ST_EXEC)
    begin
      case (ir0_reg)
        OP_MOV_DIRECT:        wEn = 1'b1;
        OP_MOV_TO_INDIRECT:
        begin
          wEn   = 1'b1;
          wAddr = r1;
        end
        OP_MOV_FROM_INDIRECT:
        begin
          wEn   = 1'b1;
          wData = r2Ind;
        end
        OP_MOV_IMMEDIATE:
        begin
          wEn   = 1'b1;
          wData = ir2_reg;
        end
        OP_POP:
        begin
          pEn   = 1'b1;
          wEn   = 1'b1;
          wData = popVal;
        end
        OP_PUSH:
        begin
          wEn   = 1'b1;
          wAddr = r1;
          pEn   = 1'b1;
          pAddr = ir1_reg;
          pData = 8'(r1 - PTR_STEP);
        end
        default:
        begin
          wEn   = isRotate;
          wData = rotOut;
        end
      endcase
    end
    else if (state_reg == ST_MEM && memLast && !isFarWrite)
    begin
      wEn   = 1'b1;
      wData = memDataIn;
    end
    else if (state_reg == ST_IDLE && regLoadEn)
    begin
      wEn   = 1'b1;
      wAddr = regLoadAddr;
      wData = regLoadData;
    end
  end

  // Result write comes last so it wins a clash with the pointer update
  always_ff @(posedge clk)
  begin
    if (pEn)
      sram[pAddr] <= pData;
    if (wEn)
      sram[wAddr] <= wData;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      state_reg   <= ST_IDLE;
      byteIdx_reg <= '0;
      wsCnt_reg   <= '0;
      cycCnt_reg  <= '0;
    end
    else
    begin
      cycCnt_reg <= state_reg == ST_IDLE || finish ? '0
                                                   : cycCnt_reg + CYC_W'(1);
      case (state_reg)
        ST_IDLE:
          if (run)
            state_reg <= ST_FETCH;
        ST_FETCH:
          if (fetchLast)
          begin
            wsCnt_reg <= '0;
            if (byteIdx_reg == bytesNeeded - 2'(1))
            begin
              state_reg   <= branchEnd ? (run ? ST_FETCH : ST_IDLE)
                                       : ST_EXEC;
              byteIdx_reg <= '0;
            end
            else
              byteIdx_reg <= byteIdx_reg + 2'(1);
          end
          else
            wsCnt_reg <= wsCnt_reg + WS_W'(1);
        ST_EXEC:
          if (isFarOp)
            state_reg <= ST_MEM;
          else if (finish)
            state_reg <= run ? ST_FETCH : ST_IDLE;
          else
            state_reg <= ST_PAD;
        ST_MEM:
          if (memLast)
          begin
            wsCnt_reg <= '0;
            state_reg <= finish ? (run ? ST_FETCH : ST_IDLE) : ST_PAD;
          end
          else
            wsCnt_reg <= wsCnt_reg + WS_W'(1);
        ST_PAD:
          if (finish)
            state_reg <= run ? ST_FETCH : ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      ir0_reg   <= '0;
      ir1_reg   <= '0;
      ir2_reg   <= '0;
      bytes_reg <= BYTE_ONE;
      total_reg <= CYC_W'(CYC_OTHER);
    end
    else if (state_reg == ST_FETCH && fetchLast)
    begin
      case (byteIdx_reg)
        2'h0:
        begin
          ir0_reg   <= memDataIn;
          bytes_reg <= fetchTiming.bytes;
          total_reg <= cmrbe_total(memDataIn, codeWaitStates,
                                   dataWaitStates);
        end
        2'h1:    ir1_reg <= memDataIn;
        default: ir2_reg <= memDataIn;
      endcase
    end
  end

  cmrbe_ret_stack u_ret_stack (
    .clk      (clk),
    .rst_n    (rst_n),
    .push     (branchEnd && ir0_reg == OP_CALL),
    .pop      (state_reg == ST_EXEC && (ir0_reg == OP_RETURN
               || ir0_reg == OP_INTERRUPT_RETURN)),
    .pushData (pc_reg + 16'(1)),
    .topData  (stackTop)
  );

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      pc_reg <= PC_RESET;
    else if (state_reg == ST_FETCH && fetchLast)
      pc_reg <= branchEnd && taken ? {memDataIn, ir1_reg}
                                   : pc_reg + 16'(1);
    else if (state_reg == ST_EXEC)
    begin
      if (ir0_reg == OP_RETURN || ir0_reg == OP_INTERRUPT_RETURN)
        pc_reg <= stackTop;
      else if (ir0_reg == OP_INDIRECT_JUMP)
        pc_reg <= farPtr1;
    end
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      memPtr_reg   <= '0;
      memWData_reg <= '0;
    end
    else if (state_reg == ST_EXEC && isFarOp)
    begin
      memPtr_reg   <= isFarWrite ? farPtr1 : farPtr2;
      memWData_reg <= r2;
    end
  end

  // Moves other than push and pop never reach this block's flag path in their execute cycle
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      flags_reg <= '0;
    else if (state_reg == ST_EXEC && isRotate)
      flags_reg.carry <= rotCarry;
    else if (flagsLoad && !(state_reg == ST_EXEC && isMove))
      flags_reg <= flagsIn;
  end

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      instrDone     <= 1'b0;
      unsupportedOp <= 1'b0;
      intReturn     <= 1'b0;
      regPeekData   <= '0;
    end
    else
    begin
      instrDone     <= finish;
      unsupportedOp <= finish && opTiming.base == CYC_OTHER
                    && !(ir0_reg == OP_RETURN
                         || ir0_reg == OP_INTERRUPT_RETURN);
      intReturn     <= state_reg == ST_EXEC
                    && ir0_reg == OP_INTERRUPT_RETURN;
      regPeekData   <= sram[regPeekAddr];
    end
  end

  // Fetches hold the code strobe low without a gap between bytes
  always_comb
  begin
    memBus.addr             = state_reg == ST_MEM ? memPtr_reg : pc_reg;
    memBus.wdata            = memWData_reg;
    memBus.dataOeN          = !(state_reg == ST_MEM && isFarWrite);
    memBus.codeReadStrobeN  = !(state_reg == ST_FETCH
      || (state_reg == ST_MEM && ir0_reg == OP_CODE_READ));
    memBus.codeWriteStrobeN = !(state_reg == ST_MEM
                                && ir0_reg == OP_CODE_WRITE);
    memBus.dataReadStrobeN  = !(state_reg == ST_MEM
                                && ir0_reg == OP_DATA_READ);
    memBus.dataWriteStrobeN = !(state_reg == ST_MEM
                                && ir0_reg == OP_DATA_WRITE);
  end

  assign progCounter = pc_reg;
  assign flags       = flags_reg;

  logic noWait;
  logic inExec;
  assign noWait = codeWaitStates == '0 && dataWaitStates == '0;
  assign inExec = state_reg == ST_EXEC;

  sequence sFetchPair;
    state_reg == ST_FETCH ##1 state_reg == ST_FETCH;
  endsequence
  sequence sDoneOp(logic [7:0] op);
    instrDone && ir0_reg == op;
  endsequence

  a_cycle_limit: assert property (@(posedge clk) disable iff (!rst_n)
    noWait |-> cycCnt_reg < CYC_W'(CYC_LIMIT))
    else $error("instruction ran past ten cycles");
  a_move_flags: assert property (@(posedge clk) disable iff (!rst_n)
    inExec && isMove |=> flags_reg == $past(flags_reg))
    else $error("move changed the flags");
  a_imm_move_len: assert property (@(posedge clk) disable iff (!rst_n)
    sDoneOp(OP_MOV_IMMEDIATE) |-> $past(cycCnt_reg) == CYC_W'(CYC_MOV_IMM)
      - CYC_W'(1) + CYC_W'(WSX_THREE) * CYC_W'(codeWaitStates))
    else $error("immediate move length wrong");
  a_pop_len: assert property (@(posedge clk) disable iff (!rst_n)
    sDoneOp(OP_POP) |-> $past(cycCnt_reg) == CYC_W'(CYC_POP)
      - CYC_W'(1) + CYC_W'(WSX_THREE) * CYC_W'(codeWaitStates))
    else $error("pop length wrong");
  a_data_read_len: assert property (@(posedge clk) disable iff (!rst_n)
    sDoneOp(OP_DATA_READ) |-> $past(cycCnt_reg) == CYC_W'(CYC_FAR_READ)
      - CYC_W'(1) + CYC_W'(WSX_FOUR) * CYC_W'(dataWaitStates))
    else $error("data read length wrong");
  a_push_pointer: assert property (@(posedge clk) disable iff (!rst_n)
    inExec && ir0_reg == OP_PUSH && r1 != ir1_reg
      |=> sram[ir1_reg] == 8'($past(r1) - PTR_STEP))
    else $error("push pointer not decremented");
  a_rotate_carry: assert property (@(posedge clk) disable iff (!rst_n)
    inExec && ir0_reg == OP_ROTATE_LEFT |=> flags_reg.carry == $past(r1[7])
      && flags_reg.zero == $past(flags_reg.zero))
    else $error("rotate left carry wrong");
  a_arith_shift: assert property (@(posedge clk) disable iff (!rst_n)
    inExec && ir0_reg == OP_ARITH_RIGHT_SHIFT && !flagsLoad
      |=> sram[ir1_reg][7] == $past(r1[7])
      && flags_reg.carry == $past(r1[0]))
    else $error("arithmetic shift wrong");
  a_jump_target: assert property (@(posedge clk) disable iff (!rst_n)
    branchEnd && ir0_reg == OP_JUMP
      |=> pc_reg == {$past(memDataIn), ir1_reg})
    else $error("jump target not absolute");
  a_fetch_strobe: assert property (@(posedge clk) disable iff (!rst_n)
    sFetchPair |-> !memBus.codeReadStrobeN
      && !$past(memBus.codeReadStrobeN))
    else $error("code strobe pulsed between fetches");

endmodule // cmrbe_core

// [rtl/cmrbe_pkg.sv]
// Shared constants and types for the move, rotate and branch executor.
// Assumes one processor clock; all pins except the asynchronous rst_n are sampled on its rising edge.
package cmrbe_pkg;

  localparam int WS_W    = 3;
  localparam int CYC_W   = 6;
  localparam int RSTK_AW = 3;

  localparam logic [15:0] PC_RESET  = 16'h0000;
  localparam logic [7:0]  PTR_STEP  = 8'h01;
  localparam logic [1:0]  BYTE_ONE  = 2'h1;
  localparam logic [1:0]  BYTE_TWO  = 2'h2;
  localparam logic [1:0]  BYTE_LAST = 2'h3;

  // Opcodes
  localparam logic [7:0] OP_MOV_DIRECT        = 8'h10;
  localparam logic [7:0] OP_MOV_TO_INDIRECT   = 8'h11;
  localparam logic [7:0] OP_MOV_FROM_INDIRECT = 8'h12;
  localparam logic [7:0] OP_MOV_IMMEDIATE     = 8'h13;
  localparam logic [7:0] OP_CODE_READ         = 8'h14;
  localparam logic [7:0] OP_CODE_WRITE        = 8'h15;
  localparam logic [7:0] OP_DATA_READ         = 8'h16;
  localparam logic [7:0] OP_DATA_WRITE        = 8'h17;
  localparam logic [7:0] OP_POP               = 8'h18;
  localparam logic [7:0] OP_PUSH              = 8'h19;
  localparam logic [7:0] OP_JUMP_IF_CARRY     = 8'h20;
  localparam logic [7:0] OP_JUMP_IF_NO_CARRY  = 8'h21;
  localparam logic [7:0] OP_JUMP_IF_ZERO      = 8'h22;
  localparam logic [7:0] OP_JUMP_IF_NONZERO   = 8'h23;
  localparam logic [7:0] OP_JUMP_IF_NEGATIVE  = 8'h24;
  localparam logic [7:0] OP_JUMP_IF_POSITIVE  = 8'h25;
  localparam logic [7:0] OP_JUMP              = 8'h26;
  localparam logic [7:0] OP_CALL              = 8'h27;
  localparam logic [7:0] OP_RETURN            = 8'h28;
  localparam logic [7:0] OP_INTERRUPT_RETURN  = 8'h29;
  localparam logic [7:0] OP_INDIRECT_JUMP     = 8'h2a;
  localparam logic [7:0] OP_ROTATE_LEFT       = 8'h30;
  localparam logic [7:0] OP_ROTATE_RIGHT      = 8'h31;
  localparam logic [7:0] OP_ROTATE_LEFT_VIA_CARRY  = 8'h32;
  localparam logic [7:0] OP_ROTATE_RIGHT_VIA_CARRY = 8'h33;
  localparam logic [7:0] OP_LOGICAL_LEFT_SHIFT  = 8'h34;
  localparam logic [7:0] OP_LOGICAL_RIGHT_SHIFT = 8'h35;
  localparam logic [7:0] OP_ARITH_RIGHT_SHIFT   = 8'h36;

  // Cycle counts at zero wait states, and extra cycles per wait state
  localparam logic [3:0] CYC_MOV_DIRECT   = 4'h5;
  localparam logic [3:0] CYC_MOV_FROM_IND = 4'h6;
  localparam logic [3:0] CYC_MOV_IMM      = 4'h4;
  localparam logic [3:0] CYC_FAR_READ     = 4'h7;
  localparam logic [3:0] CYC_FAR_WRITE    = 4'h8;
  localparam logic [3:0] CYC_POP          = 4'ha;
  localparam logic [3:0] CYC_PUSH         = 4'h9;
  localparam logic [3:0] CYC_BRANCH       = 4'h3;
  localparam logic [3:0] CYC_RETURN       = 4'h2;
  localparam logic [3:0] CYC_IND_JUMP     = 4'h4;
  localparam logic [3:0] CYC_ROTATE       = 4'h5;
  localparam logic [3:0] CYC_OTHER        = 4'h2;
  localparam logic [3:0] CYC_LIMIT        = 4'ha;
  localparam logic [2:0] WSX_ONE          = 3'h1;
  localparam logic [2:0] WSX_TWO          = 3'h2;
  localparam logic [2:0] WSX_THREE        = 3'h3;
  localparam logic [2:0] WSX_FOUR         = 3'h4;

  typedef enum logic [4:0] {
    ST_IDLE  = 5'b00001,
    ST_FETCH = 5'b00010,
    ST_EXEC  = 5'b00100,
    ST_MEM   = 5'b01000,
    ST_PAD   = 5'b10000
  } cmrbe_state_t;

  typedef struct packed {
    logic [1:0] bytes;
    logic [3:0] base;
    logic [2:0] perWs;
  } cmrbe_timing_t;

  typedef struct packed {
    logic carry;
    logic sign;
    logic zero;
  } cmrbe_flags_t;

  typedef struct packed {
    logic [15:0] addr;
    logic [7:0]  wdata;
    logic        dataOeN;
    logic        codeReadStrobeN;
    logic        codeWriteStrobeN;
    logic        dataReadStrobeN;
    logic        dataWriteStrobeN;
  } cmrbe_mem_bus_t;

  function automatic cmrbe_timing_t cmrbe_timing(input logic [7:0] op);
    cmrbe_timing_t t;
    t = '{bytes: BYTE_ONE, base: CYC_OTHER, perWs: WSX_ONE};
    case (op)
      OP_MOV_DIRECT, OP_MOV_TO_INDIRECT:
        t = '{bytes: BYTE_LAST, base: CYC_MOV_DIRECT, perWs: WSX_THREE};
      OP_MOV_FROM_INDIRECT:
        t = '{bytes: BYTE_LAST, base: CYC_MOV_FROM_IND, perWs: WSX_THREE};
      OP_MOV_IMMEDIATE:
        t = '{bytes: BYTE_LAST, base: CYC_MOV_IMM, perWs: WSX_THREE};
      OP_CODE_READ, OP_DATA_READ:
        t = '{bytes: BYTE_LAST, base: CYC_FAR_READ, perWs: WSX_FOUR};
      OP_CODE_WRITE, OP_DATA_WRITE:
        t = '{bytes: BYTE_LAST, base: CYC_FAR_WRITE, perWs: WSX_FOUR};
      OP_POP:
        t = '{bytes: BYTE_LAST, base: CYC_POP, perWs: WSX_THREE};
      OP_PUSH:
        t = '{bytes: BYTE_LAST, base: CYC_PUSH, perWs: WSX_THREE};
      OP_RETURN, OP_INTERRUPT_RETURN:
        t = '{bytes: BYTE_ONE, base: CYC_RETURN, perWs: WSX_ONE};
      OP_INDIRECT_JUMP:
        t = '{bytes: BYTE_TWO, base: CYC_IND_JUMP, perWs: WSX_TWO};
      default:
      begin
        if (op >= OP_JUMP_IF_CARRY && op <= OP_CALL)
          t = '{bytes: BYTE_LAST, base: CYC_BRANCH, perWs: WSX_THREE};
        else if (op >= OP_ROTATE_LEFT && op <= OP_ARITH_RIGHT_SHIFT)
          t = '{bytes: BYTE_TWO, base: CYC_ROTATE, perWs: WSX_TWO};
      end
    endcase
    return t;
  endfunction

  function automatic logic cmrbe_is_data_move(input logic [7:0] op);
    return op == OP_DATA_READ || op == OP_DATA_WRITE;
  endfunction

  // Whole instruction length; data moves use the data-space wait count
  function automatic logic [CYC_W-1:0] cmrbe_total(
    input logic [7:0]      op,
    input logic [WS_W-1:0] codeWs,
    input logic [WS_W-1:0] dataWs
  );
    cmrbe_timing_t   t;
    logic [WS_W-1:0] ws;
    t  = cmrbe_timing(op);
    ws = cmrbe_is_data_move(op) ? dataWs : codeWs;
    return CYC_W'(t.base) + CYC_W'(t.perWs) * CYC_W'(ws);
  endfunction

endpackage

// [rtl/cmrbe_ret_stack.sv]
// Return address stack for calls and returns.
// Assumes push and pop never assert together; overflow wraps silently.
module cmrbe_ret_stack
  import cmrbe_pkg::*;
(
  input  wire logic        clk,
  input  wire logic        rst_n,
  input  wire logic        push,
  input  wire logic        pop,
  input  wire logic [15:0] pushData,
  output logic      [15:0] topData
);
  logic [15:0]        slots [2**RSTK_AW];
  logic [RSTK_AW-1:0] depth_reg;

  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
      depth_reg <= '0;
    else if (push)
      depth_reg <= depth_reg + RSTK_AW'(1);
    else if (pop)
      depth_reg <= depth_reg - RSTK_AW'(1);
  end

  // Memory needs no reset; an empty stack returns stale contents
  always_ff @(posedge clk)
  begin
    if (push)
      slots[depth_reg] <= pushData;
  end

  assign topData = slots[depth_reg - RSTK_AW'(1)];

endmodule // cmrbe_ret_stack

// [bench/cmrbe_mem_model.sv]
// External code and data memory for the executor's parallel bus.
// Assumes reads finish within the core's wait states.
module cmrbe_mem_model
  import cmrbe_pkg::*;
(
  input  wire logic           clk,
  input  wire cmrbe_mem_bus_t memBus,
  output logic [7:0]          memDataIn
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0] codeMem [0:65535];
  logic [7:0] dataMem [0:65535];
  logic [7:0] lastByte = 8'h00;
  // Released bus shows the inverse of the last byte, so stale data fails
  always_comb
    if (!memBus.codeReadStrobeN)
      memDataIn = codeMem[memBus.addr];
    else if (!memBus.dataReadStrobeN)
      memDataIn = dataMem[memBus.addr];
    else
      memDataIn = ~lastByte;
  always @(posedge clk)
  begin
    if (!memBus.codeReadStrobeN || !memBus.dataReadStrobeN)
      lastByte <= memDataIn;
    if (!memBus.codeWriteStrobeN)
      codeMem[memBus.addr] <= memBus.wdata;
    if (!memBus.dataWriteStrobeN)
      dataMem[memBus.addr] <= memBus.wdata;
  end
endmodule // cmrbe_mem_model

// [bench/cmrbe_bench.sv]
// Self-checking bench for the move, rotate and branch executor.
// Assumes the memory model and register loads happen while idle.
module cmrbe_bench
  import cmrbe_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  logic            clk = 1'b0, rst_n = 1'b0, run = 1'b0;
  logic            flagsLoad = 1'b0, regLoadEn = 1'b0;
  logic [WS_W-1:0] codeWaitStates = '0, dataWaitStates = '0;
  logic [7:0]      memDataIn, regLoadAddr = '0, regLoadData = '0;
  logic [7:0]      regPeekAddr = '0, regPeekData;
  logic [15:0]     progCounter;
  logic            instrDone, unsupportedOp, intReturn;
  cmrbe_flags_t    flags, flagsIn = '0;
  cmrbe_mem_bus_t  memBus;
  int              nMismatch = 0, totalChecks = 0, cycles = 0;

  cmrbe_core uut (
    .clk, .rst_n, .run, .codeWaitStates, .dataWaitStates, .memDataIn,
    .memBus, .progCounter, .flags, .flagsLoad, .flagsIn, .regLoadEn,
    .regLoadAddr, .regLoadData, .regPeekAddr, .regPeekData, .instrDone,
    .unsupportedOp, .intReturn
  );
  cmrbe_mem_model mdl (.clk, .memBus, .memDataIn);

  always #4 clk = ~clk;
  always @(posedge clk)
  begin
    cycles <= cycles + 1;
    if (cycles == 3000)
    begin
      nMismatch++;
      wrapUp();
    end
  end

  task automatic chk(input string what, input logic [15:0] seen, exp);
    totalChecks++;
    if (seen !== exp)
    begin
      nMismatch++;
      $display("ERROR %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic setReg(input logic [7:0] a, d);
    @(posedge clk);
    regLoadEn <= 1'b1;
    regLoadAddr <= a;
    regLoadData <= d;
    @(posedge clk);
    regLoadEn <= 1'b0;
  endtask

  task automatic setFlags(input cmrbe_flags_t f);
    @(posedge clk);
    flagsLoad <= 1'b1;
    flagsIn <= f;
    @(posedge clk);
    flagsLoad <= 1'b0;
  endtask

  task automatic peekChk(input string what, input logic [7:0] a, exp);
    @(posedge clk);
    regPeekAddr <= a;
    repeat (2) @(posedge clk);
    #1 chk(what, regPeekData, exp);
  endtask

  // Places the bytes at the current pc and runs one instruction alone
  task automatic exec(input logic [7:0] op, a, b, input int exp);
    int n = 0;
    mdl.codeMem[progCounter] = op;
    mdl.codeMem[progCounter + 16'h1] = a;
    mdl.codeMem[progCounter + 16'h2] = b;
    @(posedge clk);
    run <= 1'b1;
    @(posedge clk);
    run <= 1'b0;
    do
    begin
      @(posedge clk);
      n++;
      #1;
    end
    while (instrDone !== 1'b1 && n < 40);
    chk("cycles", 16'(n), 16'(exp));
  endtask

  task automatic tMoves();
    @(posedge clk);
    codeWaitStates <= 3'h2;
    setFlags(3'b101);
    setReg(8'h40, 8'h34);
    setReg(8'h41, 8'h12);
    setReg(8'h50, 8'h60);
    mdl.dataMem[16'h1234] = 8'h77;
    mdl.codeMem[16'h1234] = 8'h3c;
    exec(OP_MOV_IMMEDIATE, 8'h30, 8'ha5, 10);
    exec(OP_MOV_DIRECT, 8'h31, 8'h30, 11);
    exec(OP_CODE_READ, 8'h33, 8'h40, 15);
    exec(OP_PUSH, 8'h50, 8'h31, 15);
    exec(OP_POP, 8'h34, 8'h50, 16);
    @(posedge clk);
    codeWaitStates <= '0;
    dataWaitStates <= 3'h2;
    exec(OP_DATA_READ, 8'h32, 8'h40, 15);
    exec(OP_DATA_WRITE, 8'h40, 8'h31, 16);
    peekChk("imm", 8'h30, 8'ha5);
    peekChk("cread", 8'h33, 8'h3c);
    peekChk("push", 8'h60, 8'ha5);
    peekChk("pop", 8'h34, 8'ha5);
    peekChk("ptr", 8'h50, 8'h60);
    peekChk("xread", 8'h32, 8'h77);
    chk("xwrite", mdl.dataMem[16'h1234], 8'ha5);
    exec(OP_CODE_WRITE, 8'h40, 8'h31, 8);
    exec(OP_MOV_TO_INDIRECT, 8'h40, 8'h41, 5);
    exec(OP_MOV_FROM_INDIRECT, 8'h35, 8'h40, 6);
    chk("cwrite", mdl.codeMem[16'h1234], 8'ha5);
    peekChk("toind", 8'h34, 8'h12);
    peekChk("fromind", 8'h35, 8'h12);
    chk("flags", flags, 3'b101);
    $display("moves test done");
  endtask

  task automatic tRotate();
    logic [7:0] res [0:6] = '{8'h07, 8'hc1, 8'h06, 8'h41, 8'h06, 8'h41, 8'hc1};
    for (int i = 0; i < 7; i++)
    begin
      setReg(8'h70, 8'h83);
      setFlags(3'b011);
      exec(OP_ROTATE_LEFT + 8'(i), 8'h70, 8'h00, 5);
      peekChk("rotate", 8'h70, res[i]);
      chk("rotflags", flags, 3'b111);
    end
    $display("rotate test done");
  endtask

  task automatic tBranch();
    logic [5:0]  take = 6'h25;
    logic [15:0] start;
    @(posedge clk);
    codeWaitStates <= 3'h1;
    dataWaitStates <= '0;
    setFlags(3'b101);
    for (int i = 0; i < 6; i++)
    begin
      start = progCounter;
      exec(OP_JUMP_IF_CARRY + 8'(i), 8'h5a, 8'h10 + 8'(i), 6);
      chk("cond", progCounter,
          take[i] ? {8'h10 + 8'(i), 8'h5a} : start + 16'h3);
    end
    exec(OP_JUMP, 8'h00, 8'h20, 6);
    exec(OP_CALL, 8'h00, 8'h30, 6);
    chk("call", progCounter, 16'h3000);
    exec(OP_RETURN, 8'h00, 8'h00, 3);
    chk("return", progCounter, 16'h2003);
    chk("retpulse", intReturn, 1'b0);
    setReg(8'h44, 8'h56);
    setReg(8'h45, 8'h34);
    exec(OP_INDIRECT_JUMP, 8'h44, 8'h00, 6);
    chk("indirect", progCounter, 16'h3456);
    exec(OP_CALL, 8'h00, 8'h40, 6);
    exec(OP_INTERRUPT_RETURN, 8'h00, 8'h00, 3);
    chk("interrupt_return", progCounter, 16'h3459);
    chk("iretpulse", intReturn, 1'b1);
    exec(8'h00, 8'h00, 8'h00, 3);
    chk("unsupported", unsupportedOp, 1'b1);
    $display("branch test done");
  endtask

  task automatic wrapUp();
    $display("checks %0d mismatches %0d", totalChecks, nMismatch);
    if (nMismatch == 0 && totalChecks > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  initial
  begin
    repeat (6) @(posedge clk);
    rst_n <= 1'b1;
    #1 chk("resetpc", progCounter, 16'h0000);
    tMoves();
    tRotate();
    tBranch();
    wrapUp();
  end
endmodule // cmrbe_bench
